// >>> inc/abc_pkg.sv
// Register map, field layout, reset values and timing constants.
package abc_pkg;

    // Register offsets on the serial programming port.
    localparam logic [7:0] OFF_OUT_BUF    = 8'h0a;
    localparam logic [7:0] OFF_IN_BUF     = 8'h0b;
    localparam logic [7:0] OFF_ALARM_TIME = 8'h13;
    localparam logic [7:0] OFF_PIN_EN     = 8'h14;
    localparam logic [7:0] OFF_PIN_POL    = 8'h16;
    localparam logic [7:0] OFF_ABS_MASK   = 8'h17;
    localparam logic [7:0] OFF_LOL_MASK   = 8'h18;

    // Reset values; reserved bits keep these values and are read-only.
    localparam logic [7:0] RST_OUT_BUF    = 8'h00;
    localparam logic [7:0] RST_IN_BUF     = 8'h40;
    localparam logic [7:0] RST_ALARM_TIME = 8'h2c;
    localparam logic [7:0] RST_PIN_EN     = 8'h3e;
    localparam logic [7:0] RST_PIN_POL    = 8'hdf;
    localparam logic [7:0] RST_ABS_MASK   = 8'h1f;
    localparam logic [7:0] RST_LOL_MASK   = 8'h3f;

    // Writable bits of each register.
    localparam logic [7:0] WM_OUT_BUF     = 8'h04;
    localparam logic [7:0] WM_IN_BUF      = 8'h01;
    localparam logic [7:0] WM_ALARM_TIME  = 8'h1f;
    localparam logic [7:0] WM_PIN_EN      = 8'h03;
    localparam logic [7:0] WM_PIN_POL     = 8'h07;
    localparam logic [7:0] WM_ABS_MASK    = 8'h03;
    localparam logic [7:0] WM_LOL_MASK    = 8'h01;

    // Field positions.
    localparam int BIT_OUT_BUF_DISABLE = 2;
    localparam int BIT_IN_BUF_PD       = 0;
    localparam int VAL_TIME_LSB        = 3;
    localparam int LOCK_INT_LSB        = 0;
    localparam int BIT_LOCK_LOSS_PIN_ENABLE_EN      = 1;
    localparam int BIT_INT_PIN_EN      = 0;
    localparam int BIT_BAD_POL         = 2;
    localparam int BIT_LOCK_LOSS_POLARITY         = 1;
    localparam int BIT_INTERRUPT_POLARITY         = 0;
    localparam int BIT_IN_ABS_MASK     = 1;
    localparam int BIT_XTAL_ABS_MASK   = 0;
    localparam int BIT_LOL_MASK        = 0;

    // Clock and timer tick.
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 10000;
    localparam int TICK_US       = TICK_NS / 1000;
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam int VAL_W         = 21;
    localparam int LOCK_W        = 14;

    // Validation times, least times, rounded up to whole ticks.
    localparam int VAL_T0_US = 2000;
    localparam int VAL_T1_US = 100000;
    localparam int VAL_T2_US = 200000;
    localparam int VAL_T3_US = 13000000;
    localparam logic [VAL_W-1:0] VAL_TK0 = VAL_W'((VAL_T0_US+TICK_US-1)/TICK_US);
    localparam logic [VAL_W-1:0] VAL_TK1 = VAL_W'((VAL_T1_US+TICK_US-1)/TICK_US);
    localparam logic [VAL_W-1:0] VAL_TK2 = VAL_W'((VAL_T2_US+TICK_US-1)/TICK_US);
    localparam logic [VAL_W-1:0] VAL_TK3 = VAL_W'((VAL_T3_US+TICK_US-1)/TICK_US);

    // Lock retrigger intervals, rounded down to whole ticks.
    localparam int LOCK_T0_US = 106000;
    localparam int LOCK_T1_US = 53000;
    localparam int LOCK_T2_US = 26500;
    localparam int LOCK_T3_US = 13300;
    localparam int LOCK_T4_US = 6600;
    localparam int LOCK_T5_US = 3300;
    localparam int LOCK_T6_US = 1660;
    localparam int LOCK_T7_US = 830;

endpackage : abc_pkg

// >>> verilog/abc_timer.sv
// Reloadable tick-driven countdown used for alarm timing.
`timescale 1ns/1ns
module abc_timer
    import abc_pkg::*;
#(
    parameter int W = 14
) (
    input  wire logic         sys_clk_in,
    input  wire logic         rst_in,
    input  wire logic         tick_in,
    input  wire logic         restart_in,
    input  wire logic [W-1:0] load_in,
    output logic              done_out
);

    typedef struct packed {
        logic [W-1:0] count;
        logic         done;
    } abc_tmr_s;

    abc_tmr_s state_reg;
    abc_tmr_s state_next;

    always_comb begin
        state_next = state_reg;
        if (restart_in) begin
            state_next.count = load_in;
        end else if (tick_in && state_reg.count != '0) begin
            state_next.count = W'(state_reg.count - 1'b1);
        end
        state_next.done = (state_next.count == '0);
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg      <= '0;
            state_reg.done <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign done_out = state_reg.done;

endmodule : abc_timer

// >>> verilog/abc_regs.sv
// Buffer power-down, alarm timer and status pin control registers.
// What this block does
// - Output disable bit powers down the output buffer
// - Input powerdown bit disables clock input buffer
// - Input alarm clears after selected validation time
// - Retrigger field selects lock one-shot interval
// - Each phase slip retriggers the lock one-shot
// - Lock loss pin tristated unless enabled
// - Interrupt pin enable drives interrupt status
// - Both enables clear tristates interrupt pin
// - Input bad polarity sets bad indication level
// - Lock loss polarity sets lock pin level
// - Interrupt polarity sets interrupt pin level
// - Unmasked input absent alarm raises interrupt
// - Unmasked crystal absent alarm raises interrupt
// - Mask writes never alter stored alarm flags
// - Unmasked lock loss alarm raises interrupt
`timescale 1ns/1ns
module abc_regs
    import abc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_write_in,
    input  wire logic       reg_read_in,
    input  wire logic       input_absent_in,
    input  wire logic       crystal_absent_in,
    input  wire logic       phase_slip_in,
    input  wire logic       input_bad_in,
    input  wire logic       input_bad_pin_enable_in,
    output logic      [7:0] reg_rdata_out,
    output logic            output_buffer_powerdown_out,
    output logic            input_buffer_powerdown_out,
    output logic            lock_loss_pin_out,
    output logic            lock_loss_pin_oe_out,
    output logic            interrupt_pin_out,
    output logic            interrupt_pin_oe_out,
    output logic            second_input_bad_out,
    output logic            input_absent_alarm_out,
    output logic            crystal_absent_alarm_out,
    output logic            lock_loss_out
);

    typedef struct packed {
        logic [7:0]  out_buf;
        logic [7:0]  in_buf;
        logic [7:0]  alarm_time;
        logic [7:0]  pin_en;
        logic [7:0]  pin_pol;
        logic [7:0]  abs_mask;
        logic [7:0]  lol_mask;
        logic        abs_s1;
        logic        abs_s2;
        logic        xtl_s1;
        logic        xtl_s2;
        logic        slip_s1;
        logic        slip_s2;
        logic        slip_s3;
        logic        bad_s1;
        logic        bad_s2;
        logic [15:0] tick_cnt;
        logic        tick;
        logic        in_alarm;
        logic        lock_loss;
        logic [7:0]  rdata;
        logic        obuf_pd;
        logic        ibuf_pd;
        logic        lock_loss_pin_enable;
        logic        lol_oe;
        logic        int_pin;
        logic        int_oe;
        logic        c2b;
    } abc_state_s;

    abc_state_s state_reg;
    abc_state_s state_next;

    logic [VAL_W-1:0]  val_load;
    logic [LOCK_W-1:0] lock_load;
    logic              val_done;
    logic              lock_done;
    logic              slip_edge;
    logic              irq;
    logic              wr_hit;

    // Timers run on a coarse tick so that the longest validation time fits
    // a modest counter; the cost is one tick of timing granularity.
    always_comb begin
        case (state_reg.alarm_time[VAL_TIME_LSB +: 2])
            2'h0:    val_load = VAL_TK0;
            2'h1:    val_load = VAL_TK1;
            2'h2:    val_load = VAL_TK2;
            default: val_load = VAL_TK3;
        endcase
    end

    always_comb begin
        case (state_reg.alarm_time[LOCK_INT_LSB +: 3])
            3'h0:    lock_load = LOCK_W'(LOCK_T0_US / TICK_US);
            3'h1:    lock_load = LOCK_W'(LOCK_T1_US / TICK_US);
            3'h2:    lock_load = LOCK_W'(LOCK_T2_US / TICK_US);
            3'h3:    lock_load = LOCK_W'(LOCK_T3_US / TICK_US);
            3'h4:    lock_load = LOCK_W'(LOCK_T4_US / TICK_US);
            3'h5:    lock_load = LOCK_W'(LOCK_T5_US / TICK_US);
            3'h6:    lock_load = LOCK_W'(LOCK_T6_US / TICK_US);
            default: lock_load = LOCK_W'(LOCK_T7_US / TICK_US);
        endcase
    end

    // The validation count restarts for as long as the input is absent.
    abc_timer #(
        .W(VAL_W)
    ) u_val_timer (
        .sys_clk_in(sys_clk_in),
        .rst_in    (rst_in),
        .tick_in   (state_reg.tick),
        .restart_in(state_reg.abs_s2),
        .load_in   (val_load),
        .done_out  (val_done)
    );

    abc_timer #(
        .W(LOCK_W)
    ) u_lock_oneshot (
        .sys_clk_in(sys_clk_in),
        .rst_in    (rst_in),
        .tick_in   (state_reg.tick),
        .restart_in(slip_edge),
        .load_in   (lock_load),
        .done_out  (lock_done)
    );

    assign slip_edge = state_reg.slip_s2 && !state_reg.slip_s3;
    assign wr_hit    = reg_write_in;

    always_comb begin
        irq = 1'b0;
        if (state_reg.in_alarm && !state_reg.abs_mask[BIT_IN_ABS_MASK]) begin
            irq = 1'b1;
        end
        if (state_reg.xtl_s2 && !state_reg.abs_mask[BIT_XTAL_ABS_MASK]) begin
            irq = 1'b1;
        end
        if (state_reg.lock_loss && !state_reg.lol_mask[BIT_LOL_MASK]) begin
            irq = 1'b1;
        end
    end

    always_comb begin
        state_next = state_reg;

        // Pin level inputs except input_bad_pin_enable_in are synchronised before any logic reads them.
        state_next.abs_s1  = input_absent_in;
        state_next.abs_s2  = state_reg.abs_s1;
        state_next.xtl_s1  = crystal_absent_in;
        state_next.xtl_s2  = state_reg.xtl_s1;
        state_next.slip_s1 = phase_slip_in;
        state_next.slip_s2 = state_reg.slip_s1;
        state_next.slip_s3 = state_reg.slip_s2;
        state_next.bad_s1  = input_bad_in;
        state_next.bad_s2  = state_reg.bad_s1;

        if (state_reg.tick_cnt == 16'(TICK_CYCLES - 1)) begin
            state_next.tick_cnt = 16'h0000;
            state_next.tick     = 1'b1;
        end else begin
            state_next.tick_cnt = 16'(state_reg.tick_cnt + 16'h0001);
            state_next.tick     = 1'b0;
        end

        // Reserved bits are rebuilt from the reset value on every write.
        if (wr_hit) begin
            if (reg_addr_in == OFF_OUT_BUF) begin
                state_next.out_buf = (reg_wdata_in & WM_OUT_BUF)
                                   | (RST_OUT_BUF & ~WM_OUT_BUF);
            end else if (reg_addr_in == OFF_IN_BUF) begin
                state_next.in_buf = (reg_wdata_in & WM_IN_BUF)
                                  | (RST_IN_BUF & ~WM_IN_BUF);
            end else if (reg_addr_in == OFF_ALARM_TIME) begin
                state_next.alarm_time = (reg_wdata_in & WM_ALARM_TIME)
                                      | (RST_ALARM_TIME & ~WM_ALARM_TIME);
            end else if (reg_addr_in == OFF_PIN_EN) begin
                state_next.pin_en = (reg_wdata_in & WM_PIN_EN)
                                  | (RST_PIN_EN & ~WM_PIN_EN);
            end else if (reg_addr_in == OFF_PIN_POL) begin
                state_next.pin_pol = (reg_wdata_in & WM_PIN_POL)
                                   | (RST_PIN_POL & ~WM_PIN_POL);
            end else if (reg_addr_in == OFF_ABS_MASK) begin
                state_next.abs_mask = (reg_wdata_in & WM_ABS_MASK)
                                    | (RST_ABS_MASK & ~WM_ABS_MASK);
            end else if (reg_addr_in == OFF_LOL_MASK) begin
                state_next.lol_mask = (reg_wdata_in & WM_LOL_MASK)
                                    | (RST_LOL_MASK & ~WM_LOL_MASK);
            end
        end

        // Unmapped reads return zero and leave no side effect.
        if (reg_read_in) begin
            if (reg_addr_in == OFF_OUT_BUF) begin
                state_next.rdata = state_reg.out_buf;
            end else if (reg_addr_in == OFF_IN_BUF) begin
                state_next.rdata = state_reg.in_buf;
            end else if (reg_addr_in == OFF_ALARM_TIME) begin
                state_next.rdata = state_reg.alarm_time;
            end else if (reg_addr_in == OFF_PIN_EN) begin
                state_next.rdata = state_reg.pin_en;
            end else if (reg_addr_in == OFF_PIN_POL) begin
                state_next.rdata = state_reg.pin_pol;
            end else if (reg_addr_in == OFF_ABS_MASK) begin
                state_next.rdata = state_reg.abs_mask;
            end else if (reg_addr_in == OFF_LOL_MASK) begin
                state_next.rdata = state_reg.lol_mask;
            end else begin
                state_next.rdata = 8'h00;
            end
        end

        // Alarm flags depend only on the inputs and timers, never on masks.
        state_next.in_alarm = state_reg.abs_s2
                            || (state_reg.in_alarm && !val_done);
        state_next.lock_loss      = !lock_done;

        state_next.obuf_pd = state_reg.out_buf[BIT_OUT_BUF_DISABLE];
        state_next.ibuf_pd = state_reg.in_buf[BIT_IN_BUF_PD];

        state_next.lol_oe  = state_reg.pin_en[BIT_LOCK_LOSS_PIN_ENABLE_EN];
        state_next.lock_loss_pin_enable = state_reg.lock_loss
                           ~^ state_reg.pin_pol[BIT_LOCK_LOSS_POLARITY];

        state_next.c2b = state_reg.bad_s2
                       ~^ state_reg.pin_pol[BIT_BAD_POL];

        if (state_reg.pin_en[BIT_INT_PIN_EN]) begin
            state_next.int_oe  = 1'b1;
            state_next.int_pin = irq ~^ state_reg.pin_pol[BIT_INTERRUPT_POLARITY];
        end else if (input_bad_pin_enable_in) begin
            state_next.int_oe  = 1'b1;
            state_next.int_pin = state_reg.bad_s2
                               ~^ state_reg.pin_pol[BIT_BAD_POL];
        end else begin
            state_next.int_oe  = 1'b0;
            state_next.int_pin = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg            <= '0;
            state_reg.out_buf    <= RST_OUT_BUF;
            state_reg.in_buf     <= RST_IN_BUF;
            state_reg.alarm_time <= RST_ALARM_TIME;
            state_reg.pin_en     <= RST_PIN_EN;
            state_reg.pin_pol    <= RST_PIN_POL;
            state_reg.abs_mask   <= RST_ABS_MASK;
            state_reg.lol_mask   <= RST_LOL_MASK;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata_out               = state_reg.rdata;
    assign output_buffer_powerdown_out = state_reg.obuf_pd;
    assign input_buffer_powerdown_out  = state_reg.ibuf_pd;
    assign lock_loss_pin_out           = state_reg.lock_loss_pin_enable;
    assign lock_loss_pin_oe_out        = state_reg.lol_oe;
    assign interrupt_pin_out           = state_reg.int_pin;
    assign interrupt_pin_oe_out        = state_reg.int_oe;
    assign second_input_bad_out        = state_reg.c2b;
    assign input_absent_alarm_out      = state_reg.in_alarm;
    assign crystal_absent_alarm_out    = state_reg.xtl_s2;
    assign lock_loss_out               = state_reg.lock_loss;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    a_obuf_disable: assert property (
        (reg_write_in && reg_addr_in == OFF_OUT_BUF)
        |-> ##2 output_buffer_powerdown_out
                == $past(reg_wdata_in[BIT_OUT_BUF_DISABLE], 2))
        else $error("Output buffer powerdown does not follow write.");

    a_ibuf_powerdown: assert property (
        (reg_write_in && reg_addr_in == OFF_IN_BUF)
        |-> ##2 input_buffer_powerdown_out
                == $past(reg_wdata_in[BIT_IN_BUF_PD], 2))
        else $error("Input buffer powerdown does not follow write.");

    a_val_clear_wait: assert property (
        $fell(state_reg.in_alarm)
        |-> $past(val_done) && !$past(state_reg.abs_s2))
        else $error("Input alarm cleared before validation time.");

    a_slip_retrigger: assert property (
        slip_edge |-> ##2 lock_loss_out [*2])
        else $error("Phase slip did not retrigger lock one-shot.");

    a_lol_tristate: assert property (
        !state_reg.pin_en[BIT_LOCK_LOSS_PIN_ENABLE_EN] |=> !lock_loss_pin_oe_out)
        else $error("Lock loss pin driven while disabled.");

    a_lol_polarity: assert property (
        state_reg.pin_en[BIT_LOCK_LOSS_PIN_ENABLE_EN]
        |=> lock_loss_pin_oe_out
            && lock_loss_pin_out == ($past(state_reg.lock_loss)
                ~^ $past(state_reg.pin_pol[BIT_LOCK_LOSS_POLARITY])))
        else $error("Lock loss pin level wrong.");

    a_int_drive: assert property (
        state_reg.pin_en[BIT_INT_PIN_EN]
        |=> interrupt_pin_oe_out
            && interrupt_pin_out == ($past(irq)
                ~^ $past(state_reg.pin_pol[BIT_INTERRUPT_POLARITY])))
        else $error("Interrupt pin level wrong.");

    a_int_tristate: assert property (
        (!state_reg.pin_en[BIT_INT_PIN_EN] && !input_bad_pin_enable_in)
        |=> !interrupt_pin_oe_out)
        else $error("Interrupt pin driven while both enables clear.");

    a_bad_on_int: assert property (
        (!state_reg.pin_en[BIT_INT_PIN_EN] && input_bad_pin_enable_in)
        |=> interrupt_pin_oe_out
            && interrupt_pin_out == ($past(state_reg.bad_s2)
                ~^ $past(state_reg.pin_pol[BIT_BAD_POL])))
        else $error("Input bad level wrong on interrupt pin.");

    a_all_masked: assert property (
        (state_reg.abs_mask[BIT_IN_ABS_MASK]
         && state_reg.abs_mask[BIT_XTAL_ABS_MASK]
         && state_reg.lol_mask[BIT_LOL_MASK]
         && state_reg.pin_en[BIT_INT_PIN_EN])
        |=> interrupt_pin_out == !$past(state_reg.pin_pol[BIT_INTERRUPT_POLARITY]))
        else $error("Masked alarms reached the interrupt pin.");

    c_input_alarm_clears: cover property (
        $fell(input_absent_alarm_out));

    c_lock_loss_ends: cover property (
        $fell(lock_loss_out));

    c_int_active: cover property (
        interrupt_pin_oe_out && irq);

    c_bad_on_int: cover property (
        !state_reg.pin_en[BIT_INT_PIN_EN] && input_bad_pin_enable_in
        && interrupt_pin_oe_out);

endmodule : abc_regs

// >>> test/abc_regs_tb.sv
// Self-checking testbench for the alarm and buffer control registers.
`timescale 1ns/1ns
module testbench
    import abc_pkg::*;
;
    // A short tick keeps the long alarm intervals inside a brief run.
    localparam int TK = 2;
    localparam logic [7:0] OFFS [7] = '{OFF_OUT_BUF, OFF_IN_BUF,
        OFF_ALARM_TIME, OFF_PIN_EN, OFF_PIN_POL, OFF_ABS_MASK, OFF_LOL_MASK};
    localparam logic [7:0] RSTS [7] = '{RST_OUT_BUF, RST_IN_BUF,
        RST_ALARM_TIME, RST_PIN_EN, RST_PIN_POL, RST_ABS_MASK, RST_LOL_MASK};
    localparam logic [7:0] WMS  [7] = '{WM_OUT_BUF, WM_IN_BUF,
        WM_ALARM_TIME, WM_PIN_EN, WM_PIN_POL, WM_ABS_MASK, WM_LOL_MASK};
    localparam int LT [8] = '{LOCK_T0_US / TICK_US, LOCK_T1_US / TICK_US,
        LOCK_T2_US / TICK_US, LOCK_T3_US / TICK_US, LOCK_T4_US / TICK_US,
        LOCK_T5_US / TICK_US, LOCK_T6_US / TICK_US, LOCK_T7_US / TICK_US};
    localparam int VT [2] = '{int'(VAL_TK0), int'(VAL_TK1)};

    logic       sys_clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic       reg_write_in = 1'b0;
    logic       reg_read_in = 1'b0;
    logic       input_absent_in = 1'b0;
    logic       crystal_absent_in = 1'b0;
    logic       phase_slip_in = 1'b0;
    logic       input_bad_in = 1'b0;
    logic       input_bad_pin_enable_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic       output_buffer_powerdown_out;
    logic       input_buffer_powerdown_out;
    logic       lock_loss_pin_out;
    logic       lock_loss_pin_oe_out;
    logic       interrupt_pin_out;
    logic       interrupt_pin_oe_out;
    logic       second_input_bad_out;
    logic       input_absent_alarm_out;
    logic       crystal_absent_alarm_out;
    logic       lock_loss_out;
    int         miscompares = 0;
    int         comparisons = 0;

    abc_regs #(.TICK_CYCLES(TK)) u_abc_regs (
        .sys_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
        .reg_read_in, .input_absent_in, .crystal_absent_in, .phase_slip_in,
        .input_bad_in, .input_bad_pin_enable_in, .reg_rdata_out,
        .output_buffer_powerdown_out, .input_buffer_powerdown_out,
        .lock_loss_pin_out, .lock_loss_pin_oe_out, .interrupt_pin_out,
        .interrupt_pin_oe_out, .second_input_bad_out,
        .input_absent_alarm_out, .crystal_absent_alarm_out, .lock_loss_out
    );

    always #5 sys_clk_in = ~sys_clk_in;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic chk1(input logic seen, input logic exp);
        check({7'h00, seen}, {7'h00, exp});
    endtask : chk1

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_write_in = 1'b1;
        @(negedge sys_clk_in);
        reg_write_in = 1'b0;
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk_in);
        reg_addr_in = a;
        reg_read_in = 1'b1;
        @(negedge sys_clk_in);
        reg_read_in = 1'b0;
        @(negedge sys_clk_in);
        check(reg_rdata_out, exp);
    endtask : rdchk

    // Slips are held for three clocks so the synchroniser never merges them.
    task automatic slip();
        phase_slip_in = 1'b1;
        cyc(3);
        phase_slip_in = 1'b0;
    endtask : slip

    task automatic t_reset();
        for (int i = 0; i < 7; i++) rdchk(OFFS[i], RSTS[i]);
        rdchk(8'h00, 8'h00);
        chk1(lock_loss_pin_oe_out, 1'b1);
        chk1(lock_loss_pin_out, 1'b0);
        chk1(interrupt_pin_oe_out, 1'b0);
        chk1(output_buffer_powerdown_out, 1'b0);
        chk1(input_buffer_powerdown_out, 1'b0);
    endtask : t_reset

    task automatic t_access();
        for (int i = 0; i < 7; i++) begin
            wr(OFFS[i], 8'hff);
            rdchk(OFFS[i], (RSTS[i] & ~WMS[i]) | WMS[i]);
        end
        chk1(output_buffer_powerdown_out, 1'b1);
        chk1(input_buffer_powerdown_out, 1'b1);
        for (int i = 0; i < 7; i++) begin
            wr(OFFS[i], 8'h00);
            rdchk(OFFS[i], RSTS[i] & ~WMS[i]);
        end
        chk1(output_buffer_powerdown_out, 1'b0);
        chk1(input_buffer_powerdown_out, 1'b0);
        wr(8'h0c, 8'hff);
        rdchk(8'h0c, 8'h00);
        for (int i = 0; i < 7; i++) wr(OFFS[i], RSTS[i]);
    endtask : t_access

    task automatic t_pins();
        wr(OFF_PIN_POL, 8'h05);
        cyc(2);
        chk1(lock_loss_pin_out, 1'b1);
        wr(OFF_PIN_EN, 8'h00);
        cyc(2);
        chk1(lock_loss_pin_oe_out, 1'b0);
        chk1(interrupt_pin_oe_out, 1'b0);
        for (int p = 0; p < 2; p++) begin
            wr(OFF_PIN_POL, {5'h00, p[0], 2'b01});
            input_bad_pin_enable_in = 1'b1;
            input_bad_in = 1'b1;
            cyc(6);
            chk1(interrupt_pin_oe_out, 1'b1);
            chk1(interrupt_pin_out, p[0]);
            chk1(second_input_bad_out, p[0]);
            input_bad_in = 1'b0;
            cyc(6);
            chk1(second_input_bad_out, ~p[0]);
        end
        input_bad_pin_enable_in = 1'b0;
        cyc(3);
        chk1(interrupt_pin_oe_out, 1'b0);
        wr(OFF_PIN_EN, RST_PIN_EN);
        wr(OFF_PIN_POL, RST_PIN_POL);
    endtask : t_pins

    task automatic t_lock();
        wr(OFF_ALARM_TIME, 8'h0f);
        slip();
        cyc(5);
        chk1(lock_loss_out, 1'b1);
        chk1(lock_loss_pin_out, 1'b1);
        cyc(92);
        slip();
        cyc(97);
        chk1(lock_loss_out, 1'b1);
        cyc(81);
        chk1(lock_loss_out, 1'b0);
        for (int c = 0; c < 8; c++) begin
            wr(OFF_ALARM_TIME, 8'h08 | 8'(c));
            slip();
            cyc(LT[c] * TK - 8);
            chk1(lock_loss_out, 1'b1);
            cyc(20);
            chk1(lock_loss_out, 1'b0);
        end
    endtask : t_lock

    task automatic t_valid();
        for (int v = 0; v < 2; v++) begin
            wr(OFF_ALARM_TIME, {3'b000, v[1:0], 3'b100});
            input_absent_in = 1'b1;
            cyc(10);
            chk1(input_absent_alarm_out, 1'b1);
            input_absent_in = 1'b0;
            cyc(VT[v] * TK - 10);
            chk1(input_absent_alarm_out, 1'b1);
            cyc(25);
            chk1(input_absent_alarm_out, 1'b0);
        end
        // The two long codes must outlast the time of the code two steps shorter.
        for (int v = 2; v < 4; v++) begin
            wr(OFF_ALARM_TIME, {3'b000, v[1:0], 3'b100});
            input_absent_in = 1'b1;
            cyc(10);
            input_absent_in = 1'b0;
            cyc(VT[v - 2] * TK + 25);
            chk1(input_absent_alarm_out, 1'b1);
        end
    endtask : t_valid

    task automatic t_irq();
        wr(OFF_PIN_EN, 8'h03);
        wr(OFF_PIN_POL, 8'h07);
        wr(OFF_ABS_MASK, 8'h03);
        crystal_absent_in = 1'b1;
        cyc(6);
        chk1(interrupt_pin_oe_out, 1'b1);
        chk1(interrupt_pin_out, 1'b0);
        wr(OFF_ABS_MASK, 8'h02);
        cyc(2);
        chk1(interrupt_pin_out, 1'b1);
        chk1(crystal_absent_alarm_out, 1'b1);
        wr(OFF_PIN_POL, 8'h06);
        cyc(2);
        chk1(interrupt_pin_out, 1'b0);
        wr(OFF_PIN_POL, 8'h07);
        crystal_absent_in = 1'b0;
        cyc(6);
        chk1(interrupt_pin_out, 1'b0);
        wr(OFF_ALARM_TIME, 8'h07);
        input_absent_in = 1'b1;
        cyc(6);
        chk1(interrupt_pin_out, 1'b0);
        wr(OFF_ABS_MASK, 8'h01);
        cyc(2);
        chk1(interrupt_pin_out, 1'b1);
        chk1(input_absent_alarm_out, 1'b1);
        input_absent_in = 1'b0;
        cyc(450);
        chk1(interrupt_pin_out, 1'b0);
        wr(OFF_LOL_MASK, 8'h00);
        slip();
        cyc(5);
        chk1(interrupt_pin_out, 1'b1);
        wr(OFF_PIN_EN, 8'h02);
        cyc(2);
        chk1(interrupt_pin_oe_out, 1'b0);
    endtask : t_irq

    task automatic close_out();
        if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (3) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        rst_in = 1'b0;
        t_reset();
        t_access();
        t_pins();
        t_lock();
        t_valid();
        t_irq();
        rst_in = 1'b1;
        cyc(3);
        rst_in = 1'b0;
        t_reset();
        chk1(lock_loss_out, 1'b0);
        close_out();
    end
endmodule : testbench
